// ### common/ccs_pkg.sv
// constants, types and command decoding for the calibration command and status reporter
package ccs_pkg;
    typedef enum logic [3:0] {
        CMD_DC_STEP, CMD_DC_CALC, CMD_AC_CAL, CMD_CAL_DATE,
        CMD_NEXT_DATE, CMD_CAL_SAVE, CMD_ERR_QUERY, CMD_STB_QUERY,
        CMD_OPC, CMD_OPC_QUERY, CMD_ESE, CMD_SRE,
        CMD_ESR_QUERY, CMD_CLS, CMD_UNKNOWN
    } ccs_cmd_t;
    typedef enum logic [1:0] {OP_STEP, OP_CALC, OP_AC} ccs_op_t;

    localparam int ERR_DEPTH = 8;
    localparam int DC_STEPS = 4;
    localparam int CODE_W = 16;

    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_SYNTAX = 16'hff9a;
    localparam logic [15:0] ERR_HEADER = 16'hff8f;
    localparam logic [15:0] ERR_EXEC = 16'hff38;
    localparam logic [15:0] ERR_CONFLICT = 16'hff23;
    localparam logic [15:0] ERR_RANGE = 16'hff22;
    localparam logic [15:0] ERR_NO_DATE = 16'h01b6;
    localparam logic [15:0] ERR_NO_NEXT = 16'h01b7;
    localparam logic [15:0] ERR_INCOMPLETE = 16'h01b8;

    localparam int STB_EAV = 2;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int ESR_OPC = 0;
    localparam logic [7:0] SRE_MSS_MASK = 8'hbf;
    localparam logic [7:0] OPC_ASCII = 8'h31;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    function automatic logic ccs_is_protected(input ccs_cmd_t c);
        return (c == CMD_DC_STEP) || (c == CMD_DC_CALC) || (c == CMD_CAL_DATE) ||
               (c == CMD_NEXT_DATE) || (c == CMD_CAL_SAVE);
    endfunction
endpackage

// ### common/ccs_mem_if.sv
// carrier between the controller and the error queue memory
`timescale 1ns/100ps
interface ccs_mem_if #(parameter int AW = 3, parameter int DW = 16);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### design/ccs_err_mem.sv
// error queue storage with registered read data
`timescale 1ns/100ps
module ccs_err_mem #(
    parameter int DEPTH = ccs_pkg::ERR_DEPTH,
    parameter int AW = 3,
    parameter int DW = ccs_pkg::CODE_W
) (
    input wire logic mclk,
    ccs_mem_if.mem port
);
    logic [DW-1:0] store [DEPTH];
    logic [DW-1:0] rdata_reg;

    // no reset on storage: an entry is only read after it was written
    always_ff @(posedge mclk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
        rdata_reg <= store[port.raddr];
    end
    assign port.rdata = rdata_reg;
endmodule // ccs_err_mem

// ### design/ccs_top.sv
// calibration command sequencer with error queue and status byte
`timescale 1ns/100ps
module ccs_top #(
    parameter int QDEPTH = ccs_pkg::ERR_DEPTH,
    parameter int NSTEPS = ccs_pkg::DC_STEPS
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input ccs_pkg::ccs_cmd_t cmd_code,
    input wire logic cmd_syntax_err,
    input wire logic cmd_param_ok,
    input wire logic [$clog2(NSTEPS)-1:0] cmd_step,
    input wire logic [7:0] cmd_value,
    output logic cmd_ready,
    input wire logic cal_unlocked,
    input wire logic cal_done,
    output logic cal_start,
    output ccs_pkg::ccs_op_t cal_op,
    output logic [$clog2(NSTEPS)-1:0] cal_step,
    output logic inputs_open_req,
    output logic ac_consts_active,
    output logic dc_consts_save,
    output logic [15:0] resp_data,
    input wire logic resp_read,
    output logic [7:0] status_byte,
    output logic srq
);
    localparam int AW = $clog2(QDEPTH);
    localparam int SW = $clog2(NSTEPS);
    localparam logic [AW:0] Q_FULL = (AW+1)'(QDEPTH);
    localparam logic [AW:0] Q_ZERO = '0;
    localparam logic [NSTEPS-1:0] ALL_STEPS = '1;

    typedef enum {ST_IDLE, ST_BUSY, ST_ERR_RD} ccs_state_t;

    // ************************************************************
    // state
    // ************************************************************
    ccs_state_t state_reg, state_next;
    logic [NSTEPS-1:0] steps_reg;
    logic calc_reg, date_reg, ndate_reg;
    logic [7:0] esr_reg, ese_reg, sre_reg;
    logic opc_arm_reg, opcq_arm_reg;
    logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [AW:0] cnt_reg, cnt_next;
    logic mav_reg;
    logic [15:0] resp_reg;
    logic start_reg, save_reg, ac_act_reg;
    ccs_pkg::ccs_op_t op_reg;
    logic [SW-1:0] step_reg;
    logic [7:0] stb_reg;

    ccs_mem_if #(.AW(AW), .DW(ccs_pkg::CODE_W)) qbus ();
    ccs_err_mem #(.DEPTH(QDEPTH), .AW(AW), .DW(ccs_pkg::CODE_W)) u_mem (
        .mclk(mclk),
        .port(qbus.mem)
    );

    // ************************************************************
    // command acceptance and error decode
    // ************************************************************
    wire is_opc_kind = (cmd_code == ccs_pkg::CMD_OPC) || (cmd_code == ccs_pkg::CMD_OPC_QUERY);
    // opc commands are taken while busy so that they can wait for the running calibration operation
    assign cmd_ready = (state_reg == ST_IDLE) || ((state_reg == ST_BUSY) && is_opc_kind);
    wire take = cmd_valid && cmd_ready;
    wire syn_e = cmd_syntax_err;
    wire hdr_e = (cmd_code == ccs_pkg::CMD_UNKNOWN);
    wire lock_e = ccs_pkg::ccs_is_protected(cmd_code) && !cal_unlocked;
    wire range_e = (cmd_code == ccs_pkg::CMD_DC_STEP) && !cmd_param_ok;
    wire all_steps = (steps_reg == ALL_STEPS);
    wire order_e = (cmd_code == ccs_pkg::CMD_DC_CALC) && !all_steps;
    wire is_save = (cmd_code == ccs_pkg::CMD_CAL_SAVE);
    wire date_e = is_save && !date_reg;
    wire ndate_e = is_save && !ndate_reg;
    wire proc_e = is_save && !(all_steps && calc_reg);
    wire any_e = syn_e || hdr_e || lock_e || range_e || order_e || date_e || ndate_e || proc_e;
    wire [15:0] err_code = syn_e ? ccs_pkg::ERR_SYNTAX :
                           hdr_e ? ccs_pkg::ERR_HEADER :
                           lock_e ? ccs_pkg::ERR_CONFLICT :
                           range_e ? ccs_pkg::ERR_RANGE :
                           order_e ? ccs_pkg::ERR_EXEC :
                           date_e ? ccs_pkg::ERR_NO_DATE :
                           ndate_e ? ccs_pkg::ERR_NO_NEXT : ccs_pkg::ERR_INCOMPLETE;
    wire ok = take && !any_e;
    wire ok_cmd_is_cal = ok && ((cmd_code == ccs_pkg::CMD_DC_STEP) || (cmd_code == ccs_pkg::CMD_DC_CALC) ||
                                (cmd_code == ccs_pkg::CMD_AC_CAL));
    wire cls = ok && (cmd_code == ccs_pkg::CMD_CLS);
    wire err_q = ok && (cmd_code == ccs_pkg::CMD_ERR_QUERY);
    wire esr_q = ok && (cmd_code == ccs_pkg::CMD_ESR_QUERY);
    wire stb_q = ok && (cmd_code == ccs_pkg::CMD_STB_QUERY);

    // ************************************************************
    // error queue
    // ************************************************************
    wire q_empty = (cnt_reg == Q_ZERO);
    wire pop = err_q && !q_empty;
    // a full queue drops the newest error rather than losing the oldest
    wire push = take && any_e && ((cnt_reg != Q_FULL) || pop);
    assign cnt_next = cls ? Q_ZERO : (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
    assign qbus.we = push;
    assign qbus.waddr = wr_ptr_reg;
    assign qbus.wdata = err_code;
    assign qbus.raddr = rd_ptr_reg;

    // ************************************************************
    // sequencing
    // ************************************************************
    wire op_end = (state_reg == ST_BUSY) && cal_done;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ok_cmd_is_cal) begin
                    state_next = ST_BUSY;
                end else if (pop) begin
                    state_next = ST_ERR_RD;
                end
            end
            ST_BUSY: begin
                if (cal_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_ERR_RD: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    wire idle_now = (state_reg == ST_IDLE);
    wire opc_fire = opc_arm_reg && idle_now;
    wire opcq_fire = opcq_arm_reg && idle_now;
    localparam logic [7:0] BYTE0 = ccs_pkg::BYTE_ZERO;
    wire [7:0] esr_set = opc_fire ? (8'h01 << ccs_pkg::ESR_OPC) : BYTE0;
    // hardware set wins over a read or clear in the same cycle
    wire [7:0] esr_next = ((esr_q || cls) ? BYTE0 : esr_reg) | esr_set;

    // ************************************************************
    // status byte
    // ************************************************************
    wire eav = !q_empty;
    wire esb = |(esr_reg & ese_reg);
    wire [7:0] stb_low = (8'(eav) << ccs_pkg::STB_EAV) | (8'(mav_reg) << ccs_pkg::STB_MAV) |
                         (8'(esb) << ccs_pkg::STB_ESB);
    wire mss = |(stb_low & sre_reg & ccs_pkg::SRE_MSS_MASK);
    wire [7:0] stb_w = stb_low | (8'(mss) << ccs_pkg::STB_MSS);

    wire load_err = (state_reg == ST_ERR_RD);
    wire load_empty = err_q && q_empty;
    wire resp_load = load_err || load_empty || esr_q || stb_q || opcq_fire;
    wire [15:0] resp_w = load_err ? qbus.rdata :
                         load_empty ? ccs_pkg::ERR_NONE :
                         esr_q ? {BYTE0, esr_reg} :
                         stb_q ? {BYTE0, stb_w} : {BYTE0, ccs_pkg::OPC_ASCII};

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= Q_ZERO;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_ptr_reg <= cls ? '0 : (push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg);
            rd_ptr_reg <= cls ? '0 : (pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            esr_reg <= BYTE0;
            ese_reg <= BYTE0;
            sre_reg <= BYTE0;
            opc_arm_reg <= 1'b0;
            opcq_arm_reg <= 1'b0;
            mav_reg <= 1'b0;
            resp_reg <= '0;
            stb_reg <= BYTE0;
        end else begin
            esr_reg <= esr_next;
            ese_reg <= (ok && (cmd_code == ccs_pkg::CMD_ESE)) ? cmd_value : ese_reg;
            sre_reg <= (ok && (cmd_code == ccs_pkg::CMD_SRE)) ? cmd_value : sre_reg;
            opc_arm_reg <= (ok && (cmd_code == ccs_pkg::CMD_OPC)) || (opc_arm_reg && !opc_fire && !cls);
            opcq_arm_reg <= (ok && (cmd_code == ccs_pkg::CMD_OPC_QUERY)) || (opcq_arm_reg && !opcq_fire);
            mav_reg <= resp_load || (mav_reg && !resp_read);
            resp_reg <= resp_load ? resp_w : resp_reg;
            stb_reg <= stb_w;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            steps_reg <= '0;
            calc_reg <= 1'b0;
            date_reg <= 1'b0;
            ndate_reg <= 1'b0;
            start_reg <= 1'b0;
            save_reg <= 1'b0;
            ac_act_reg <= 1'b0;
            op_reg <= ccs_pkg::OP_STEP;
            step_reg <= '0;
        end else begin
            start_reg <= ok_cmd_is_cal;
            save_reg <= ok && is_save;
            if (ok_cmd_is_cal) begin
                op_reg <= (cmd_code == ccs_pkg::CMD_DC_STEP) ? ccs_pkg::OP_STEP :
                          (cmd_code == ccs_pkg::CMD_DC_CALC) ? ccs_pkg::OP_CALC : ccs_pkg::OP_AC;
                step_reg <= cmd_step;
            end
            if (op_end && (op_reg == ccs_pkg::OP_STEP)) begin
                steps_reg <= steps_reg | (NSTEPS'(1) << step_reg);
            end
            if (op_end && (op_reg == ccs_pkg::OP_CALC)) begin
                calc_reg <= 1'b1;
            end
            // ac constants stay active until reset_n clears them; nothing writes them back
            if (op_end && (op_reg == ccs_pkg::OP_AC)) begin
                ac_act_reg <= 1'b1;
            end
            date_reg <= date_reg || (ok && (cmd_code == ccs_pkg::CMD_CAL_DATE));
            ndate_reg <= ndate_reg || (ok && (cmd_code == ccs_pkg::CMD_NEXT_DATE));
            if (ok && is_save) begin
                steps_reg <= '0;
                calc_reg <= 1'b0;
            end
        end
    end

    assign cal_start = start_reg;
    assign cal_op = op_reg;
    assign cal_step = step_reg;
    assign inputs_open_req = (state_reg == ST_BUSY) && (op_reg == ccs_pkg::OP_AC);
    assign ac_consts_active = ac_act_reg;
    assign dc_consts_save = save_reg;
    assign resp_data = resp_reg;
    assign status_byte = stb_reg;
    assign srq = stb_reg[ccs_pkg::STB_MSS];

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_opcq_idle;
        take && (cmd_code == ccs_pkg::CMD_OPC_QUERY) && !any_e && idle_now && !opcq_arm_reg;
    endsequence
    sequence s_err_taken;
        take && any_e && (cnt_reg == Q_ZERO) && !cls;
    endsequence

    property p_opcq;
        @(posedge mclk) disable iff (!reset_n)
        s_opcq_idle |-> ##2 (mav_reg && (resp_reg == {BYTE0, ccs_pkg::OPC_ASCII}));
    endproperty
    a_opcq: assert property (p_opcq) else $error("opc query gave no ascii 1");

    property p_eav;
        @(posedge mclk) disable iff (!reset_n)
        s_err_taken |=> (cnt_reg == (AW+1)'(1)) ##1 status_byte[ccs_pkg::STB_EAV];
    endproperty
    a_eav: assert property (p_eav) else $error("error not queued or eav not set");

    property p_empty_zero;
        @(posedge mclk) disable iff (!reset_n)
        (err_q && q_empty) |=> (mav_reg && (resp_reg == ccs_pkg::ERR_NONE));
    endproperty
    a_empty_zero: assert property (p_empty_zero) else $error("empty queue read not zero");

    property p_pop_order;
        @(posedge mclk) disable iff (!reset_n)
        (pop && (cnt_reg == (AW+1)'(1))) |=> !eav ##1 (mav_reg && !status_byte[ccs_pkg::STB_EAV]);
    endproperty
    a_pop_order: assert property (p_pop_order) else $error("last pop left eav set");

    property p_mav_clear;
        @(posedge mclk) disable iff (!reset_n)
        (resp_read && !resp_load) |=> !mav_reg ##1 !status_byte[ccs_pkg::STB_MAV];
    endproperty
    a_mav_clear: assert property (p_mav_clear) else $error("mav stayed after read");

    property p_esr_read;
        @(posedge mclk) disable iff (!reset_n)
        (esr_q && !opc_fire) |=> (esr_reg == BYTE0) && (resp_reg[7:0] == $past(esr_reg));
    endproperty
    a_esr_read: assert property (p_esr_read) else $error("event register read wrong");

    property p_cls;
        @(posedge mclk) disable iff (!reset_n)
        // an opc event in the clearing cycle still lands: set wins
        cls |=> (cnt_reg == Q_ZERO) && !opc_arm_reg &&
                (esr_reg == ($past(opc_fire) ? (8'h01 << ccs_pkg::ESR_OPC) : BYTE0));
    endproperty
    a_cls: assert property (p_cls) else $error("clear status incomplete");

    property p_srq;
        @(posedge mclk) disable iff (!reset_n)
        ((sre_reg == 8'h04) && eav) |=> srq;
    endproperty
    a_srq: assert property (p_srq) else $error("no srq on error");

    property p_locked;
        @(posedge mclk) disable iff (!reset_n)
        (take && lock_e && !syn_e && !hdr_e) |->
            (qbus.we == (cnt_reg != Q_FULL)) && (qbus.wdata == ccs_pkg::ERR_CONFLICT) ##1 !cal_start;
    endproperty
    a_locked: assert property (p_locked) else $error("locked command not refused");

    property p_order;
        @(posedge mclk) disable iff (!reset_n)
        (take && order_e && !syn_e && !hdr_e && !lock_e) |-> (qbus.wdata == ccs_pkg::ERR_EXEC) ##1 !cal_start;
    endproperty
    a_order: assert property (p_order) else $error("early calc not refused");

    property p_esb;
        @(posedge mclk) disable iff (!reset_n)
        (opc_fire && ese_reg[ccs_pkg::ESR_OPC]) |-> ##2 status_byte[ccs_pkg::STB_ESB];
    endproperty
    a_esb: assert property (p_esb) else $error("esb not set on opc");
endmodule // ccs_top

// ### test/ccs_cal_engine.sv
// calibration engine model answering each started operation after a set delay
`timescale 1ns/100ps
module ccs_cal_engine (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cal_start,
    input wire logic [3:0] dly,
    output logic cal_done
);
    logic [3:0] cnt_reg;
    logic busy_reg;
    // delay latched at start so a bench change mid-operation cannot shorten it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            cal_done <= 1'b0;
            if (cal_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= dly;
            end else if (busy_reg) begin
                if (cnt_reg == 4'h0) begin
                    cal_done <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end
endmodule // ccs_cal_engine

// ### test/tb_top.sv
// self-checking bench for the calibration command and status reporter
`timescale 1ns/100ps
module tb_top;
    logic mclk, reset_n, cmd_valid, cmd_syntax_err, cmd_param_ok, cmd_ready, cal_unlocked, cal_done, cal_start;
    ccs_pkg::ccs_cmd_t cmd_code;
    ccs_pkg::ccs_op_t cal_op;
    logic [1:0] cmd_step, cal_step;
    logic [7:0] cmd_value, status_byte;
    logic inputs_open_req, ac_consts_active, dc_consts_save, resp_read, srq;
    logic [15:0] resp_data;
    logic [3:0] dly;
    int n_fail, n_checks, seed, n_save, n_open, i;
    int err_q[$];
    logic mav_m;
    logic [7:0] esr_m, ese_m, sre_m;
    ccs_top uut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_syntax_err(cmd_syntax_err), .cmd_param_ok(cmd_param_ok), .cmd_step(cmd_step),
        .cmd_value(cmd_value), .cmd_ready(cmd_ready), .cal_unlocked(cal_unlocked), .cal_done(cal_done),
        .cal_start(cal_start), .cal_op(cal_op), .cal_step(cal_step), .inputs_open_req(inputs_open_req),
        .ac_consts_active(ac_consts_active), .dc_consts_save(dc_consts_save), .resp_data(resp_data),
        .resp_read(resp_read), .status_byte(status_byte), .srq(srq));
    ccs_cal_engine eng (.mclk(mclk), .reset_n(reset_n), .cal_start(cal_start), .dly(dly), .cal_done(cal_done));
    // ****************************************
    // clock, monitors, reporting
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (dc_consts_save === 1'b1) n_save++;
        if (inputs_open_req === 1'b1 && cal_op === ccs_pkg::OP_AC) n_open++;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_resp(input string n, input logic [15:0] e);
        n_checks++;
        if (resp_data !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, resp_data);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_field(input string n, input logic [3:0] e, input logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] exp_stb();
        logic [7:0] b;
        b = 8'h00;
        b[ccs_pkg::STB_EAV] = (err_q.size() > 0);
        b[ccs_pkg::STB_MAV] = mav_m;
        b[ccs_pkg::STB_ESB] = |(esr_m & ese_m);
        b[ccs_pkg::STB_MSS] = |(b & sre_m & ccs_pkg::SRE_MSS_MASK);
        return b;
    endfunction
    task automatic chk_stb();
        logic [7:0] e;
        e = exp_stb();
        n_checks++;
        if (status_byte !== e) begin
            n_fail++;
            $display("MISMATCH status_byte expected %h seen %h", e, status_byte);
        end
        chk_bit("srq", e[ccs_pkg::STB_MSS], srq);
    endtask
    // ****************************************
    // bus-side drivers
    // ****************************************
    task automatic send(input ccs_pkg::ccs_cmd_t c, input logic se = 1'b0, input logic pok = 1'b1,
                        input logic [1:0] st = 2'h0, input logic [7:0] v = 8'h00);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_syntax_err = se;
        cmd_param_ok = pok;
        cmd_step = st;
        cmd_value = ((c == ccs_pkg::CMD_ESE) || (c == ccs_pkg::CMD_SRE)) ? v : 8'($random(seed));
        dly = 4'($random(seed));
        repeat (300) begin
            if (cmd_ready === 1'b1) break;
            @(negedge mclk);
        end
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task automatic push(input int e);
        if (err_q.size() < 8) err_q.push_back(e);
    endtask
    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask
    task automatic wait_idle();
        repeat (300) begin
            if (cmd_ready === 1'b1) break;
            @(negedge mclk);
        end
        settle();
    endtask
    task automatic wait_bit(input int b);
        repeat (300) begin
            if (status_byte[b] === 1'b1) break;
            @(negedge mclk);
        end
        settle();
    endtask
    task automatic rd();
        @(negedge mclk);
        resp_read = 1'b1;
        @(negedge mclk);
        resp_read = 1'b0;
        mav_m = 1'b0;
        settle();
    endtask
    // answer word checked before the read, status after it
    task automatic err_read();
        int e;
        send(ccs_pkg::CMD_ERR_QUERY);
        settle();
        e = (err_q.size() > 0) ? err_q.pop_front() : 0;
        chk_resp("error_code", 16'(e));
        mav_m = 1'b1;
        rd();
        chk_stb();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        #(40 * 20000);
        n_fail++;
        finish_test();
    end
    initial begin
        n_fail = 0; n_checks = 0; seed = 80788; n_save = 0; n_open = 0;
        mav_m = 1'b0; esr_m = 8'h00; ese_m = 8'h00; sre_m = 8'h00;
        reset_n = 1'b0; cmd_valid = 1'b0; cmd_code = ccs_pkg::CMD_STB_QUERY; cmd_syntax_err = 1'b0;
        cmd_param_ok = 1'b1; cmd_step = 2'h0; cmd_value = 8'h00; cal_unlocked = 1'b0; resp_read = 1'b0;
        dly = 4'h0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        chk_stb();
        err_read();
        // locked, malformed and unknown commands, then overflow of the queue
        send(ccs_pkg::CMD_DC_STEP); push(-221);
        chk_bit("refused_start", 1'b0, cal_start);
        send(ccs_pkg::CMD_DC_STEP, 1'b1); push(-102);
        send(ccs_pkg::CMD_UNKNOWN); push(-113);
        for (i = 0; i < 6; i++) begin
            send(ccs_pkg::CMD_DC_CALC, 1'b1); push(-102);
        end
        settle();
        chk_stb();
        for (i = 0; i < 9; i++) err_read();
        // ordering, range, dates and completeness with the lock open
        cal_unlocked = 1'b1;
        send(ccs_pkg::CMD_DC_CALC); push(-200);
        send(ccs_pkg::CMD_DC_STEP, 1'b0, 1'b0); push(-222);
        err_read();
        err_read();
        for (i = 0; i < 4; i++) begin
            send(ccs_pkg::CMD_DC_STEP, 1'b0, 1'b1, 2'(i));
            chk_bit("cal_start", 1'b1, cal_start);
            chk_field("cal_step", 4'(i), 4'(cal_step));
            chk_field("cal_op", 4'(ccs_pkg::OP_STEP), 4'(cal_op));
            send(ccs_pkg::CMD_OPC_QUERY);
            wait_bit(ccs_pkg::STB_MAV);
            mav_m = 1'b1;
            chk_stb();
            chk_resp("opc_reply", {8'h00, ccs_pkg::OPC_ASCII});
            rd();
            chk_stb();
        end
        send(ccs_pkg::CMD_DC_CALC);
        wait_idle();
        send(ccs_pkg::CMD_CAL_SAVE); push(438);
        send(ccs_pkg::CMD_CAL_DATE);
        send(ccs_pkg::CMD_CAL_SAVE); push(439);
        send(ccs_pkg::CMD_NEXT_DATE);
        send(ccs_pkg::CMD_CAL_SAVE);
        settle();
        chk_bit("dc_save_count", 1'b1, n_save == 1);
        send(ccs_pkg::CMD_CAL_SAVE); push(440);
        for (i = 0; i < 3; i++) err_read();
        // user ac calibration with completion through the event register
        send(ccs_pkg::CMD_ESE, 1'b0, 1'b1, 2'h0, 8'h01); ese_m = 8'h01;
        chk_bit("ac_before", 1'b0, ac_consts_active);
        send(ccs_pkg::CMD_AC_CAL);
        chk_field("cal_op_ac", 4'(ccs_pkg::OP_AC), 4'(cal_op));
        send(ccs_pkg::CMD_OPC); esr_m = 8'h01;
        wait_bit(ccs_pkg::STB_ESB);
        chk_stb();
        chk_bit("inputs_open_seen", 1'b1, n_open > 0);
        chk_bit("inputs_open_idle", 1'b0, inputs_open_req);
        chk_bit("ac_after", 1'b1, ac_consts_active);
        send(ccs_pkg::CMD_ESR_QUERY);
        settle();
        chk_resp("esr_reply", 16'h0001);
        esr_m = 8'h00; mav_m = 1'b1;
        rd();
        chk_stb();
        // service request on error, then clear status
        send(ccs_pkg::CMD_SRE, 1'b0, 1'b1, 2'h0, 8'h04); sre_m = 8'h04;
        send(ccs_pkg::CMD_UNKNOWN); push(-113);
        settle();
        chk_stb();
        send(ccs_pkg::CMD_OPC); esr_m = 8'h01;
        settle();
        chk_stb();
        send(ccs_pkg::CMD_CLS); err_q.delete(); esr_m = 8'h00;
        settle();
        chk_stb();
        err_read();
        finish_test();
    end
endmodule // tb_top
